// File: include/rpp_map.svh
// Purpose: constants for the rapid pin port
// Assumes: word offsets on the local platform bus, byte addresses
// Notes: block decodes a small window of its own
// Functional notes
// - sixteen pins, slave on local bus
// - byte, word, longword accesses with lanes
// - every access done in one cycle
// - set, clear, toggle alias addresses
// - separate direction and pin enable registers
// - read pins where direction is zero, data register where one; write data drives outputs
// - zero wait states, no interrupt
`ifndef RPP_MAP_SVH
`define RPP_MAP_SVH
// ======================================================
// register map
`define RPP_OFF_DIR    4'h0
`define RPP_OFF_DATA   4'h4
`define RPP_OFF_ENB    4'h8
`define RPP_OFF_CLR    4'hc
`define RPP_OFF_SET    4'h4
`define RPP_OFF_TOG    4'hc
`define RPP_BANK_MAIN  1'b0
`define RPP_BANK_ALT   1'b1
`define RPP_DIR_RST    16'h0000
`define RPP_DATA_RST   16'h0000
`define RPP_ENB_RST    16'h0000
`define RPP_WORD_HI    1'b0
// ======================================================
// address fields
`define RPP_BANK_BIT   4
`define RPP_WOFF_HI    3
`define RPP_WOFF_LO    2
`define RPP_WOFF_PAD   2'h0
`define RPP_HALF_BIT   1
`define RPP_BYTE_BIT   0
// ======================================================
// byte lane masks, lane 3 is bus bits 31:24
`define RPP_LANE_BYTE0 4'h8
`define RPP_LANE_HI    4'hc
`define RPP_LANE_LO    4'h3
`define RPP_LANE_ALL   4'hf
`define RPP_RDATA_RST  32'h0000_0000
`endif

// File: include/rpp_pkg.sv
// Purpose: types for the rapid pin port
// Assumes: constants come from rpp_map.svh
// Notes: one state struct per module
package rpp_pkg;
   typedef enum logic [1:0] {
      RPP_SZ_BYTE = 2'h0,
      RPP_SZ_HALF = 2'h1,
      RPP_SZ_WORD = 2'h2
   } rpp_size_t;

   typedef enum logic [2:0] {
      RPP_OP_WRITE = 3'h1,
      RPP_OP_SET   = 3'h2,
      RPP_OP_CLR   = 3'h4
   } rpp_op_t;

   typedef struct packed {
      logic [15:0] dir;
      logic [15:0] data;
      logic [15:0] enb;
      logic [31:0] rdata;
   } rpp_state_t;

   typedef struct packed {
      logic [15:0] s1;
      logic [15:0] s2;
   } rpp_sync_state_t;
endpackage

// File: rtl/rpp_port.sv
// Purpose: rapid pin port, 16-bit gpio on the local platform bus
// Assumes: bus presents address, size and write data in the data phase
// Notes: no wait states; no interrupt output exists
`timescale 1ns/1ps
`include "rpp_map.svh"
module rpp_port #(
   parameter int PINS = 16
) (
   input  wire logic            clk_sys_in,
   input  wire logic            arst_n_in,
   input  wire logic            bus_sel_in,
   input  wire logic            bus_wr_in,
   input  wire logic [4:0]      bus_addr_in,
   input  wire logic [1:0]      bus_size_in,
   input  wire logic [31:0]     bus_wdata_in,
   output logic      [31:0]     bus_rdata_out,
   output logic                 bus_ready_out,
   output logic                 bus_err_out,
   input  wire logic [PINS-1:0] pin_in,
   output logic      [PINS-1:0] pin_out,
   output logic      [PINS-1:0] pin_oe_out,
   output logic      [PINS-1:0] pin_en_out
);
   // ======================================================
   // state: registers live in one struct, next copy built below
   rpp_pkg::rpp_state_t st_q;
   rpp_pkg::rpp_state_t st_d;

   // ======================================================
   // decode and datapath nets
   logic [PINS-1:0]     pin_sync;
   logic                alt;
   logic [3:0]          woff;
   logic                wr_go;
   logic                rd_go;

   logic                hit_dir;
   logic                hit_data;
   logic                hit_enb;
   logic                hit_clr;
   logic                hit_set;
   logic                hit_tog;
   logic                hit_rdata;

   logic [3:0]          lane;
   logic [31:0]         bmask;
   logic [15:0]         m_lo;
   logic [15:0]         m_hi;
   logic [15:0]         w_lo;
   logic [15:0]         w_hi;
   logic [15:0]         wmask;
   logic [15:0]         wval;

   logic [15:0]         rd_pins;
   logic [15:0]         dir_nx;
   logic [15:0]         data_nx;
   logic [15:0]         enb_nx;
   logic [15:0]         rsel;
   logic [31:0]         rword;

   // ======================================================
   // pin input synchroniser
   // pins are asynchronous, so nothing reads pin_in before two flops
   rpp_sync #(.WIDTH(PINS)) u_sync (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .async_in   (pin_in),
      .sync_out   (pin_sync)
   );

   // ======================================================
   // address decode
   // byte address bits are dropped so narrow accesses hit the same register
   assign alt   = bus_addr_in[`RPP_BANK_BIT];
   assign woff  = {bus_addr_in[`RPP_WOFF_HI:`RPP_WOFF_LO], `RPP_WOFF_PAD};
   assign wr_go = bus_sel_in & bus_wr_in;
   assign rd_go = bus_sel_in & ~bus_wr_in;

   // the alias bank holds set and toggle; clear sits in the main bank
   always_comb begin
      hit_dir  = 1'b0;
      hit_data = 1'b0;
      hit_enb  = 1'b0;
      hit_clr  = 1'b0;
      hit_set  = 1'b0;
      hit_tog  = 1'b0;
      if (alt == `RPP_BANK_MAIN) begin
         unique case (woff)
            `RPP_OFF_DIR:  hit_dir  = 1'b1;
            `RPP_OFF_DATA: hit_data = 1'b1;
            `RPP_OFF_ENB:  hit_enb  = 1'b1;
            `RPP_OFF_CLR:  hit_clr  = 1'b1;
            default:       hit_dir  = 1'b0;
         endcase
      end else begin
         unique case (woff)
            `RPP_OFF_SET:  hit_set  = 1'b1;
            `RPP_OFF_TOG:  hit_tog  = 1'b1;
            default:       hit_set  = 1'b0;
         endcase
      end
   end

   // alias addresses read back as the data view
   assign hit_rdata = hit_data | hit_clr | hit_set | hit_tog;

   // ======================================================
   // byte lanes, big-endian on the bus
   always_comb begin
      unique case (rpp_pkg::rpp_size_t'(bus_size_in))
         rpp_pkg::RPP_SZ_BYTE: lane = `RPP_LANE_BYTE0 >> bus_addr_in[`RPP_HALF_BIT:`RPP_BYTE_BIT];
         rpp_pkg::RPP_SZ_HALF: lane = bus_addr_in[`RPP_HALF_BIT] ? `RPP_LANE_LO : `RPP_LANE_HI;
         default:              lane = `RPP_LANE_ALL;
      endcase
   end

   // one mask byte per bus lane
   generate
      for (genvar i = 0; i < 4; i++) begin : g_lane
         assign bmask[i*8 +: 8] = {8{lane[i]}};
      end
   endgenerate

   // ======================================================
   // write data merge
   // each register is 16 bits in the low half; the high half is a free mirror
   // both halves are or-merged, so a longword with different halves sets the union
   assign m_hi  = bmask[31:16];
   assign m_lo  = bmask[15:0];
   assign w_hi  = bus_wdata_in[31:16];
   assign w_lo  = bus_wdata_in[15:0];
   assign wmask = m_lo | m_hi;
   assign wval  = (w_lo & m_lo) | (w_hi & m_hi);

   // ======================================================
   // per-pin read view
   // direction one reads the driven value, zero the synchronised pin
   generate
      for (genvar p = 0; p < PINS; p++) begin : g_pin
         assign rd_pins[p] = st_q.dir[p] ? st_q.data[p] : pin_sync[p];
      end
   endgenerate

   // ======================================================
   // register writes
   // alias stores touch only the data register, no read-modify-write needed
   // a clear takes the masked ones, so unselected lanes are left alone
   always_comb begin
      dir_nx  = st_q.dir;
      data_nx = st_q.data;
      enb_nx  = st_q.enb;
      if (wr_go) begin
         if (hit_dir) begin
            dir_nx = (st_q.dir & ~wmask) | wval;
         end
         if (hit_enb) begin
            enb_nx = (st_q.enb & ~wmask) | wval;
         end
         if (hit_data) begin
            data_nx = (st_q.data & ~wmask) | wval;
         end
         if (hit_set) begin
            data_nx = st_q.data | wval;
         end
         if (hit_clr) begin
            data_nx = st_q.data & ~wval;
         end
         if (hit_tog) begin
            data_nx = st_q.data ^ wval;
         end
      end
   end

   // ======================================================
   // read word
   // unselected lanes and unmapped offsets return zero
   always_comb begin
      rsel = 16'h0000;
      if (rd_go) begin
         if (hit_dir) begin
            rsel = st_q.dir;
         end else if (hit_enb) begin
            rsel = st_q.enb;
         end else if (hit_rdata) begin
            rsel = rd_pins;
         end
      end
      rword = {rsel, rsel} & bmask;
   end

   // ======================================================
   // next state
   // rdata reloads every cycle, so it reads zero when idle
   always_comb begin
      st_d       = st_q;
      st_d.dir   = dir_nx;
      st_d.data  = data_nx;
      st_d.enb   = enb_nx;
      st_d.rdata = rword;
   end

   // read data is registered, so it stands in the cycle after the access
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q.dir   <= `RPP_DIR_RST;
         st_q.data  <= `RPP_DATA_RST;
         st_q.enb   <= `RPP_ENB_RST;
         st_q.rdata <= `RPP_RDATA_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ======================================================
   // outputs
   // ready is tied, so every access completes in one data phase
   // no interrupt exists: pin edges are only seen through reads
   // drive needs both direction and enable; data alone only sets the level
   assign bus_rdata_out = st_q.rdata;
   assign bus_ready_out = 1'b1;
   assign bus_err_out   = 1'b0;
   assign pin_out       = st_q.data;
   assign pin_oe_out    = st_q.dir & st_q.enb;
   assign pin_en_out    = st_q.enb;
endmodule // rpp_port

// File: rtl/rpp_sync.sv
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: pins are asynchronous to clk_sys_in
// Notes: first stage read only by the second
`timescale 1ns/1ps
module rpp_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_sys_in,
   input  wire logic             arst_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   rpp_pkg::rpp_sync_state_t st_q;
   rpp_pkg::rpp_sync_state_t st_d;

   always_comb begin
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;
endmodule // rpp_sync

// File: sim/rpp_pin_model.sv
// Purpose: pad model beside the port
// Assumes: undriven pads follow an outside level
// Notes: no pull, outside level set by the bench
`timescale 1ns/1ps
module rpp_pin_model (
   input  wire logic [15:0] drv_in,
   input  wire logic [15:0] oe_in,
   input  wire logic [15:0] ext_in,
   output logic      [15:0] pin_lvl_out
);
   // =====
   // pad level
   assign pin_lvl_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // rpp_pin_model

// File: sim/rpp_port_bench.sv
// Purpose: bench for rpp_port
// Assumes: inputs change on the falling edge
// Notes: sel stays up between calls, so writes go back to back
`timescale 1ns/1ps
module rpp_port_bench;
   // =====
   // bench
   logic        clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, rdy, err;
   logic [4:0]  addr = 5'h00;
   logic [1:0]  size = 2'h2;
   logic [31:0] wd = 32'h0, rd;
   logic [15:0] ext = 16'hc3c3, lvl, po, oe, en;
   int          n_fail = 0, tests_run = 0;
   rpp_port u_dut (.clk_sys_in(clk), .arst_n_in(rst_n), .bus_sel_in(sel), .bus_wr_in(wr), .bus_addr_in(addr),
      .bus_size_in(size), .bus_wdata_in(wd), .bus_rdata_out(rd), .bus_ready_out(rdy), .bus_err_out(err),
      .pin_in(lvl), .pin_out(po), .pin_oe_out(oe), .pin_en_out(en));
   rpp_pin_model u_pins (.drv_in(po), .oe_in(oe), .ext_in(ext), .pin_lvl_out(lvl));
   initial forever #5 clk = ~clk;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic w, input logic [4:0] a, input logic [1:0] s, input logic [31:0] d);
      @(negedge clk);
      sel = 1'b1;
      wr = w;
      addr = a;
      size = s;
      wd = d;
   endtask
   task automatic rd_reg(input logic [4:0] a, input logic [1:0] s, input logic [31:0] exp);
      op(1'b0, a, s, 32'h0);
      @(negedge clk);
      cmp(rd, exp);
   endtask
   task automatic idle();
      @(negedge clk);
      sel = 1'b0;
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      final_report();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      cmp({po, oe}, 32'h0);
      cmp(en, 32'h0);
      cmp({rdy, err}, 32'h2);
      op(1'b1, 5'h00, 2'h2, {2{16'hff0f}});
      op(1'b1, 5'h08, 2'h2, {2{16'h0ff0}});
      op(1'b1, 5'h04, 2'h2, 32'h0000_1234);
      idle();
      cmp({po, oe}, 32'h1234_0f00);
      cmp(en, 32'h0ff0);
      op(1'b1, 5'h14, 2'h2, {2{16'h00f0}});
      op(1'b1, 5'h0c, 2'h2, {2{16'h0004}});
      op(1'b1, 5'h1c, 2'h2, {2{16'h0101}});
      idle();
      cmp(po, 32'h13f1);
      op(1'b1, 5'h06, 2'h1, 32'hffff_a55a);
      op(1'b1, 5'h04, 2'h0, 32'h11ff_ffff);
      op(1'b1, 5'h10, 2'h2, 32'hffff_ffff);
      idle();
      cmp(po, 32'h115a);
      cmp({rdy, err}, 32'h2);
      rd_reg(5'h04, 2'h2, {2{16'h11ca}});
      rd_reg(5'h06, 2'h0, 32'h0000_1100);
      rd_reg(5'h00, 2'h1, 32'hff0f_0000);
      rd_reg(5'h10, 2'h2, 32'h0);
      ext = 16'h3c3c;
      repeat (3) idle();
      rd_reg(5'h1c, 2'h2, {2{16'h113a}});
      // mid-run reset: all registers back to zero, pins read as inputs
      idle();
      rst_n = 1'b0;
      idle();
      cmp({po, oe}, 32'h0);
      cmp(en, 32'h0);
      cmp(rd, 32'h0);
      rst_n = 1'b1;
      repeat (2) idle();
      rd_reg(5'h04, 2'h2, {2{16'h3c3c}});
      final_report();
   end
endmodule // rpp_port_bench

// File: sim/rpp_port_chk.sv
// Purpose: port checks for rpp_port
// Assumes: one clock, async low reset
// Notes: w merges both halves as the port does
`timescale 1ns/1ps
module rpp_port_chk #(parameter int PINS = 16) (
   input wire logic            clk_sys_in,
   input wire logic            arst_n_in,
   input wire logic            bus_sel_in,
   input wire logic            bus_wr_in,
   input wire logic [4:0]      bus_addr_in,
   input wire logic [1:0]      bus_size_in,
   input wire logic [31:0]     bus_wdata_in,
   input wire logic [31:0]     bus_rdata_out,
   input wire logic            bus_ready_out,
   input wire logic            bus_err_out,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe_out,
   input wire logic [PINS-1:0] pin_en_out
);
   // =====
   // checks
   wire [15:0] w = bus_wdata_in[31:16] | bus_wdata_in[15:0];
   wire        w32 = bus_sel_in & bus_wr_in & (bus_size_in == 2'h2);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   chk_ready_high: assert property (bus_ready_out) else $error("ready low");
   chk_no_err: assert property (!bus_err_out) else $error("err high");
   chk_drive_gated: assert property ((pin_oe_out & ~pin_en_out) == 16'h0) else $error("oe");
   chk_idle_zero: assert property (!bus_sel_in |=> bus_rdata_out == 32'h0) else $error("rdata");
   chk_data_write: assert property (w32 && bus_addr_in == 5'h04 |=> pin_out == $past(w)) else $error("data");
   chk_set_alias: assert property (w32 && bus_addr_in == 5'h14 |=> pin_out == ($past(pin_out) | $past(w)))
      else $error("set");
   chk_clr_alias: assert property (w32 && bus_addr_in == 5'h0c |=> pin_out == ($past(pin_out) & ~$past(w)))
      else $error("clr");
   chk_tog_alias: assert property (w32 && bus_addr_in == 5'h1c |=> pin_out == ($past(pin_out) ^ $past(w)))
      else $error("tog");
   chk_half_lane: assert property (bus_sel_in && bus_wr_in && bus_size_in == 2'h1 && bus_addr_in == 5'h06
      |=> pin_out == $past(bus_wdata_in[15:0])) else $error("half");
   chk_alt_hole: assert property (bus_sel_in && bus_wr_in && bus_addr_in[4] && !bus_addr_in[2]
      |=> $stable(pin_out) && $stable(pin_en_out) && $stable(pin_oe_out)) else $error("hole");
   chk_enb_write: assert property (w32 && bus_addr_in == 5'h08 |=> pin_en_out == $past(w)) else $error("enb");
   chk_read_keeps: assert property (bus_sel_in && !bus_wr_in |=> $stable(pin_out)) else $error("read");
   cover property (w32 && bus_addr_in == 5'h1c);
   cover property (bus_sel_in && bus_wr_in && bus_size_in == 2'h0);
   cover property (bus_sel_in && !bus_wr_in ##1 bus_sel_in);
endmodule // rpp_port_chk
bind rpp_port rpp_port_chk #(.PINS(PINS)) u_chk (.*);
